//--- shared/cpureg_defines.svh
// Offsets, field positions, reset values and region bounds of the processor register set
`ifndef CPUREG_DEFINES_SVH
`define CPUREG_DEFINES_SVH
// General registers mapped into data memory
`define CPUREG_GPR_BASE 20'hFFEF8
`define CPUREG_GPR_LAST 20'hFFEFF
// Peripheral register window
`define CPUREG_SFR_BASE 20'hFFF00
`define CPUREG_SFR_LAST 20'hFFFFF
// Default bank for 16-bit data addresses
`define CPUREG_DATA_DEFAULT_HI 4'hF
// Reset vector byte addresses
`define CPUREG_RST_VEC_LO 20'h00000
`define CPUREG_RST_VEC_HI 20'h00001
// Reset values
`define CPUREG_STATUS_RESET 8'h06
`define CPUREG_DBANK_RESET 8'h0F
`define CPUREG_CBANK_RESET 8'h00
`define CPUREG_FETCH_HI_RESET 4'h0
// Status word bit positions
`define CPUREG_BIT_CARRY 0
`define CPUREG_BIT_SVC_LO 1
`define CPUREG_BIT_SVC_HI 2
`define CPUREG_BIT_HC 4
`define CPUREG_BIT_ZERO 6
`define CPUREG_BIT_IRQ 7
`endif

//--- shared/cpureg_pkg.sv
// Types shared by the processor register set
package cpureg_pkg;
    // Flag update request from the execution pipeline
    typedef struct packed {
        logic upd_zero;
        logic val_zero;
        logic upd_hc;
        logic val_hc;
        logic upd_cy;
        logic val_cy;
    } cpureg_flags_s;

    // Fetch pointer operations
    typedef enum logic [1:0] {
        CPUREG_PC_HOLD = 2'b00,
        CPUREG_PC_STEP = 2'b01,
        CPUREG_PC_JUMP = 2'b10,
        CPUREG_PC_JREG = 2'b11
    } cpureg_pcop_e;

    // Reset sequencer states
    typedef enum logic [1:0] {
        CPUREG_RS_VLO = 2'b00,
        CPUREG_RS_VHI = 2'b01,
        CPUREG_RS_RUN = 2'b10
    } cpureg_rst_e;

    // Stack operations
    typedef enum logic [1:0] {
        CPUREG_SP_NONE = 2'b00,
        CPUREG_SP_PUSH = 2'b01,
        CPUREG_SP_POP = 2'b10,
        CPUREG_SP_LOAD = 2'b11
    } cpureg_spop_e;
endpackage

//--- hdl/cpureg_addr_map.sv
// Data address extension and region decode
`timescale 1ns/1ns
`default_nettype none
`include "cpureg_defines.svh"
module cpureg_addr_map (
    // Instruction side
    input wire logic [15:0] offset,
    input wire logic use_bank,
    input wire logic [7:0] data_bank,
    // Decoded address
    output logic [19:0] full_addr,
    output logic hit_gpr,
    output logic hit_sfr,
    output logic [2:0] gpr_index
);
    import cpureg_pkg::*;
    wire logic [3:0] hi_bits;
    // Bank bits above the offset, else the top 64 KB
    assign hi_bits = use_bank ? data_bank[3:0] : `CPUREG_DATA_DEFAULT_HI; // [RULE19] [RULE21]
    assign full_addr = {hi_bits, offset}; // [RULE17]
    // Region decode of the final address
    assign hit_gpr = (full_addr >= `CPUREG_GPR_BASE) && (full_addr <= `CPUREG_GPR_LAST); // [RULE16]
    assign hit_sfr = (full_addr >= `CPUREG_SFR_BASE); // [RULE20]
    assign gpr_index = full_addr[2:0];
endmodule
`default_nettype wire

//--- hdl/cpureg_core.sv
// Processor register set: fetch pointer, status word, stack pointer, general and bank registers
// Operation
// [RULE1] 20-bit fetch pointer steps by instruction length
// [RULE2] Branch loads pointer from immediate or register
// [RULE3] Reset loads vector bytes, upper bits zero
// [RULE4] Status word 8 bits, resets to 06H
// [RULE5] Status pushed on acknowledge, restored on return
// [RULE6] Accept flag low refuses every maskable interrupt
// [RULE7] Accept flag cleared by disable/acknowledge, set by enable
// [RULE8] Zero flag set on zero or equal
// [RULE9] Half-carry set on bit 3 carry/borrow
// [RULE10] Lower priority than service level refused
// [RULE11] Carry holds overflow, shift-out, bit accumulator
// [RULE12] Stack pointer predecrements on write, postincrements read
// [RULE13] Software initialises stack pointer before use
// [RULE14] Stack lives only in internal RAM
// [RULE15] No fetch or stack in general registers
// [RULE16] Eight byte registers, pairable, memory mapped
// [RULE17] Bank registers extend data and branch addresses
// [RULE18] Data bank resets 0FH, code bank 00H
// [RULE19] Default data window is the top 64 KB
// [RULE20] Peripheral window decoded at FFF00H upward
// [RULE21] Data bank low nibble above 16-bit offset
`timescale 1ns/1ns
`default_nettype none
`include "cpureg_defines.svh"
module cpureg_core (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Reset vector fetch
    output logic vec_req,
    output logic [19:0] vec_addr,
    input wire logic vec_valid,
    input wire logic [7:0] vec_data,
    output logic core_ready,
    // Fetch pointer control
    input wire cpureg_pkg::cpureg_pcop_e pc_op,
    input wire logic [2:0] instr_len,
    input wire logic [19:0] branch_target,
    input wire logic [15:0] branch_reg,
    output logic [19:0] next_fetch_pointer,
    // Status word control
    input wire cpureg_pkg::cpureg_flags_s flag_upd,
    input wire logic status_load,
    input wire logic [7:0] status_wdata,
    input wire logic block_irq_instr,
    input wire logic allow_irq_instr,
    input wire logic irq_ack,
    output logic [7:0] status_word,
    output logic [7:0] status_push_data,
    output logic status_push,
    // Interrupt gating
    input wire logic irq_pending,
    input wire logic [1:0] irq_level,
    output logic irq_take,
    // Stack pointer
    input wire cpureg_pkg::cpureg_spop_e sp_op,
    input wire logic [15:0] sp_wdata,
    output logic [15:0] stack_top_ptr,
    output logic [19:0] stack_addr,
    // Data access
    input wire logic [15:0] data_offset,
    input wire logic data_use_bank,
    input wire logic data_we,
    input wire logic [7:0] data_wdata,
    output logic [19:0] data_addr,
    output logic data_hit_sfr,
    output logic [7:0] gpr_rdata,
    // Register pair port
    input wire logic [1:0] pair_sel,
    input wire logic pair_we,
    input wire logic [15:0] pair_wdata,
    output logic [15:0] pair_rdata,
    // Bank registers
    input wire logic dbank_we,
    input wire logic cbank_we,
    input wire logic [7:0] bank_wdata,
    output logic [7:0] data_bank_reg,
    output logic [7:0] code_bank_reg
);
    import cpureg_pkg::*;

    // ==========================================================
    // Reset sequencer
    // ==========================================================
    cpureg_rst_e rs_r, rs_nxt;
    logic [19:0] pc_r, pc_nxt;
    wire logic [19:0] pc_vec_lo;
    wire logic [19:0] pc_vec_hi;
    // Vector bytes: low at even address, high at odd; top nibble zero
    assign pc_vec_lo = {`CPUREG_FETCH_HI_RESET, pc_r[15:8], vec_data}; // [RULE3]
    assign pc_vec_hi = {`CPUREG_FETCH_HI_RESET, vec_data, pc_r[7:0]}; // [RULE3]
    assign vec_req = (rs_r != CPUREG_RS_RUN);
    assign vec_addr = (rs_r == CPUREG_RS_VLO) ? `CPUREG_RST_VEC_LO : `CPUREG_RST_VEC_HI;
    assign core_ready = (rs_r == CPUREG_RS_RUN);

    // Sequencer next state waits on memory
    always_comb begin
        rs_nxt = rs_r;
        unique case (rs_r)
            CPUREG_RS_VLO: begin
                if (vec_valid) begin
                    rs_nxt = CPUREG_RS_VHI;
                end
            end
            CPUREG_RS_VHI: begin
                if (vec_valid) begin
                    rs_nxt = CPUREG_RS_RUN;
                end
            end
            CPUREG_RS_RUN: begin
                rs_nxt = CPUREG_RS_RUN;
            end
            default: begin
                rs_nxt = CPUREG_RS_VLO;
            end
        endcase
    end

    // Reset re-arms the vector fetch from the low byte
    always_ff @(posedge clk) begin
        if (rst) begin
            rs_r <= CPUREG_RS_VLO;
        end else begin
            rs_r <= rs_nxt;
        end
    end

    // ==========================================================
    // Fetch pointer
    // ==========================================================
    wire logic [19:0] pc_step;
    wire logic [19:0] pc_jreg;
    // Carry out of bit 19 is dropped, so the pointer wraps
    assign pc_step = pc_r + {17'h00000, instr_len}; // [RULE1]
    // Register-direct branches take the code bank as upper bits
    assign pc_jreg = {code_bank_reg[3:0], branch_reg}; // [RULE17]

    // Pipeline ops are ignored until the vector is in
    always_comb begin
        pc_nxt = pc_r;
        if (rs_r == CPUREG_RS_VLO && vec_valid) begin
            pc_nxt = pc_vec_lo;
        end else if (rs_r == CPUREG_RS_VHI && vec_valid) begin
            pc_nxt = pc_vec_hi;
        end else if (rs_r == CPUREG_RS_RUN) begin
            unique case (pc_op)
                CPUREG_PC_HOLD: pc_nxt = pc_r;
                CPUREG_PC_STEP: pc_nxt = pc_step; // [RULE1]
                CPUREG_PC_JUMP: pc_nxt = branch_target; // [RULE2]
                CPUREG_PC_JREG: pc_nxt = pc_jreg; // [RULE2]
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            pc_r <= 20'h00000; // [RULE3]
        end else begin
            pc_r <= pc_nxt;
        end
    end
    assign next_fetch_pointer = pc_r;

    // ==========================================================
    // Status word and interrupt gating
    // ==========================================================
    logic [7:0] psw_r, psw_nxt;
    wire logic [1:0] svc_level;
    // Service level is held in bits 2:1 of the status word
    assign svc_level = {psw_r[`CPUREG_BIT_SVC_HI], psw_r[`CPUREG_BIT_SVC_LO]};
    // Smaller level number is higher priority; the level must not exceed service level
    assign irq_take = core_ready && irq_pending && psw_r[`CPUREG_BIT_IRQ] && (irq_level <= svc_level); // [RULE6] [RULE10]
    // Current word goes to the stack as the acknowledge happens
    assign status_push = irq_ack; // [RULE5]
    assign status_push_data = psw_r;

    // Restore has priority over single-flag updates, ack over enable
    always_comb begin
        psw_nxt = psw_r;
        if (status_load) begin
            psw_nxt = status_wdata; // [RULE5]
        end else begin
            if (flag_upd.upd_zero) begin
                psw_nxt[`CPUREG_BIT_ZERO] = flag_upd.val_zero; // [RULE8]
            end
            if (flag_upd.upd_hc) begin
                psw_nxt[`CPUREG_BIT_HC] = flag_upd.val_hc; // [RULE9]
            end
            if (flag_upd.upd_cy) begin
                psw_nxt[`CPUREG_BIT_CARRY] = flag_upd.val_cy; // [RULE11]
            end
            if (block_irq_instr || irq_ack) begin
                psw_nxt[`CPUREG_BIT_IRQ] = 1'b0; // [RULE7]
            end else if (allow_irq_instr) begin
                psw_nxt[`CPUREG_BIT_IRQ] = 1'b1; // [RULE7]
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            psw_r <= `CPUREG_STATUS_RESET; // [RULE4]
        end else begin
            psw_r <= psw_nxt;
        end
    end
    assign status_word = psw_r;

    // ==========================================================
    // Stack pointer
    // ==========================================================
    logic [15:0] sp_r, sp_nxt;
    wire logic [15:0] sp_dec;
    assign sp_dec = sp_r - 16'h0001;
    // Push writes at the decremented slot; pop reads the current top
    assign stack_addr = {`CPUREG_DATA_DEFAULT_HI, (sp_op == CPUREG_SP_PUSH) ? sp_dec : sp_r}; // [RULE12]

    // Not gated by core_ready; the pipeline only issues stack ops while running
    always_comb begin
        unique case (sp_op)
            CPUREG_SP_NONE: sp_nxt = sp_r;
            CPUREG_SP_PUSH: sp_nxt = sp_dec; // [RULE12]
            CPUREG_SP_POP: sp_nxt = sp_r + 16'h0001; // [RULE12]
            CPUREG_SP_LOAD: sp_nxt = sp_wdata; // [RULE13]
        endcase
    end

    // Reset clears it to 0000H; software must load it first
    always_ff @(posedge clk) begin
        if (rst) begin
            sp_r <= 16'h0000;
        end else begin
            sp_r <= sp_nxt;
        end
    end
    assign stack_top_ptr = sp_r;

    // ==========================================================
    // Bank registers
    // ==========================================================
    // All eight bits kept for readback; only the low nibble extends addresses
    logic [7:0] dbank_r, cbank_r;
    always_ff @(posedge clk) begin
        if (rst) begin
            dbank_r <= `CPUREG_DBANK_RESET; // [RULE18]
            cbank_r <= `CPUREG_CBANK_RESET; // [RULE18]
        end else begin
            if (dbank_we) begin
                dbank_r <= bank_wdata;
            end
            if (cbank_we) begin
                cbank_r <= bank_wdata;
            end
        end
    end
    assign data_bank_reg = dbank_r;
    assign code_bank_reg = cbank_r;

    // ==========================================================
    // Address extension and general registers
    // ==========================================================
    // Decode kept in its own module so the address path stays purely combinational
    wire logic hit_gpr;
    wire logic [2:0] gpr_index;
    cpureg_addr_map u_map (
        .offset(data_offset),
        .use_bank(data_use_bank),
        .data_bank(dbank_r),
        .full_addr(data_addr),
        .hit_gpr(hit_gpr),
        .hit_sfr(data_hit_sfr),
        .gpr_index(gpr_index)
    );

    // Eight byte registers; pair n is bytes 2n (low) and 2n+1 (high)
    logic [7:0] gpr_r [0:7];
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi = gi + 1) begin : g_gpr
            wire logic byte_we;
            wire logic pair_hit;
            assign byte_we = data_we && hit_gpr && (gpr_index == 3'(gi)); // [RULE16]
            assign pair_hit = pair_we && (pair_sel == 2'(gi / 2)); // [RULE16]
            always_ff @(posedge clk) begin
                if (rst) begin
                    gpr_r[gi] <= 8'h00;
                end else if (pair_hit) begin
                    gpr_r[gi] <= pair_wdata[(gi % 2) * 8 +: 8];
                end else if (byte_we) begin
                    gpr_r[gi] <= data_wdata;
                end
            end
        end
    endgenerate

    // Reads outside the general block return zero
    assign gpr_rdata = hit_gpr ? gpr_r[gpr_index] : 8'h00;
    // Pair reads ignore the data address, so both read ports work in one cycle
    assign pair_rdata = {gpr_r[{pair_sel, 1'b1}], gpr_r[{pair_sel, 1'b0}]}; // [RULE16]
endmodule
`default_nettype wire

//--- testbench/cpureg_core_sva.sv
// Assertion checker for the processor register set
`timescale 1ns/1ns
`default_nettype none
module cpureg_core_sva (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Fetch pointer
    input wire logic core_ready,
    input wire cpureg_pkg::cpureg_pcop_e pc_op,
    input wire logic [2:0] instr_len,
    input wire logic [19:0] branch_target,
    input wire logic [15:0] branch_reg,
    input wire logic [19:0] next_fetch_pointer,
    // Status and interrupts
    input wire logic [7:0] status_word,
    input wire logic status_load,
    input wire logic block_irq_instr,
    input wire logic irq_ack,
    input wire logic status_push,
    input wire logic [7:0] status_push_data,
    input wire logic [1:0] irq_level,
    input wire logic irq_take,
    // Stack, data and banks
    input wire cpureg_pkg::cpureg_spop_e sp_op,
    input wire logic [15:0] stack_top_ptr,
    input wire logic [15:0] data_offset,
    input wire logic data_use_bank,
    input wire logic [19:0] data_addr,
    input wire logic data_hit_sfr,
    input wire logic [7:0] data_bank_reg,
    input wire logic [7:0] code_bank_reg
);
    import cpureg_pkg::*;
    logic [19:0] jreg_tgt;
    // ====
    // Register-direct target, compared one edge later
    assign jreg_tgt = {code_bank_reg[3:0], branch_reg};
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // Values left by reset, seen at the first edge after release
    a_status_reset: assert property ($past(rst) |-> status_word == 8'h06)
        else $error("status word reset value wrong");
    a_bank_reset: assert property ($past(rst) |-> {data_bank_reg, code_bank_reg} == 16'h0F00)
        else $error("bank reset values wrong");
    // Fetch pointer moves
    a_pc_step: assert property (core_ready && pc_op == CPUREG_PC_STEP |=>
        next_fetch_pointer == $past(next_fetch_pointer) + 20'($past(instr_len))) else $error("step wrong");
    a_pc_jump: assert property (core_ready && pc_op == CPUREG_PC_JUMP |=>
        next_fetch_pointer == $past(branch_target)) else $error("jump wrong");
    a_pc_jreg: assert property (core_ready && pc_op == CPUREG_PC_JREG |=>
        next_fetch_pointer == $past(jreg_tgt)) else $error("register jump wrong");
    // Interrupt gating; a low accept flag must win over any level
    a_irq_gate: assert property (irq_take |->
        core_ready && status_word[7] && irq_level <= status_word[2:1]) else $error("interrupt taken while gated");
    a_irq_clear: assert property ((irq_ack || block_irq_instr) && !status_load |=> !status_word[7])
        else $error("accept flag not cleared");
    a_push_word: assert property (irq_ack |-> status_push && status_push_data == status_word)
        else $error("status push wrong");
    a_sp_push: assert property (sp_op == CPUREG_SP_PUSH |=>
        stack_top_ptr == $past(stack_top_ptr) - 16'h0001) else $error("stack push wrong");
    // Address extension and peripheral decode are combinational
    a_data_bank: assert property (
        data_addr == {(data_use_bank ? data_bank_reg[3:0] : 4'hF), data_offset}) else $error("data address wrong");
    a_sfr_hit: assert property (data_hit_sfr == (data_addr >= 20'hFFF00))
        else $error("peripheral decode wrong");
endmodule
bind cpureg_core cpureg_core_sva u_sva (.clk, .rst, .core_ready, .pc_op, .instr_len, .branch_target, .branch_reg,
    .next_fetch_pointer, .status_word, .status_load, .block_irq_instr, .irq_ack, .status_push, .status_push_data,
    .irq_level, .irq_take, .sp_op, .stack_top_ptr, .data_offset, .data_use_bank, .data_addr, .data_hit_sfr,
    .data_bank_reg, .code_bank_reg);
`default_nettype wire

//--- testbench/cpureg_vec_model.sv
// Behavioural reset-vector memory beside the register set
`timescale 1ns/1ns
`default_nettype none
module cpureg_vec_model #(
    parameter logic [15:0] VEC = 16'h1234
) (
    // Clock, reset and pace
    input wire logic clk,
    input wire logic rst,
    input wire logic slow,
    // Vector fetch
    input wire logic vec_req,
    input wire logic [19:0] vec_addr,
    output logic vec_valid,
    output logic [7:0] vec_data
);
    logic [1:0] wait_r;
    logic go;
    // ====
    // Answer after the pace delay, then idle a cycle; idle data toggles so stale bytes never pass
    assign go = !rst && vec_req && !vec_valid && (!slow || wait_r == 2'h3);
    always_ff @(posedge clk) begin
        vec_valid <= go;
        wait_r <= (rst || go || !vec_req) ? 2'h0 : wait_r + 2'h1;
        vec_data <= rst ? 8'h5A : go ? (vec_addr[0] ? VEC[15:8] : VEC[7:0]) : ~vec_data;
    end
endmodule
`default_nettype wire

//--- testbench/cpureg_core_tb.sv
// Self-checking bench for the processor register set
`timescale 1ns/1ns
`default_nettype none
module cpureg_core_tb;
    import cpureg_pkg::*;
    logic clk, rst, slow, vec_req, vec_valid, core_ready, status_load, block_irq_instr, allow_irq_instr, irq_ack;
    logic status_push, irq_pending, irq_take, data_use_bank, data_we, data_hit_sfr, pair_we, dbank_we, cbank_we;
    logic [19:0] vec_addr, branch_target, next_fetch_pointer, stack_addr, data_addr;
    logic [15:0] branch_reg, sp_wdata, stack_top_ptr, data_offset, pair_wdata, pair_rdata;
    logic [7:0] vec_data, status_wdata, status_word, status_push_data, data_wdata, gpr_rdata, bank_wdata;
    logic [7:0] data_bank_reg, code_bank_reg;
    logic [2:0] instr_len;
    logic [1:0] irq_level, pair_sel;
    cpureg_pcop_e pc_op;
    cpureg_flags_s flag_upd;
    cpureg_spop_e sp_op;
    int fail_count, cmp_count, cyc;
    cpureg_core u_dut (.*);
    cpureg_vec_model u_vec (.*);
    // ====
    // Clock and a cycle ceiling far above the few dozen cycles used
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            fail_count++;
            stop_test();
        end
    end
    task automatic chk(input string what, input logic [39:0] seen, input logic [39:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // Steps requested before the vector is in must be ignored
    task automatic t_reset(input logic pace);
        slow = pace;
        rst = 1'b1;
        pc_op = CPUREG_PC_STEP;
        tick(3);
        rst = 1'b0;
        for (int i = 0; i < 20 && core_ready !== 1'b1; i++) tick(1);
        chk("vector", next_fetch_pointer, 20'h01234);
        chk("status", status_word, 8'h06);
        chk("banks", {data_bank_reg, code_bank_reg}, 16'h0F00);
        pc_op = CPUREG_PC_HOLD;
        $display("reset test done");
    endtask
    task automatic t_fetch();
        logic [19:0] exp;
        exp = next_fetch_pointer;
        pc_op = CPUREG_PC_STEP;
        for (int n = 1; n < 8; n++) begin
            instr_len = 3'(n);
            tick(1);
            exp = exp + 20'(n);
            chk("step", next_fetch_pointer, exp);
        end
        pc_op = CPUREG_PC_JUMP;
        branch_target = 20'hFFFFE;
        tick(1);
        chk("jump", next_fetch_pointer, 20'hFFFFE);
        pc_op = CPUREG_PC_STEP;
        instr_len = 3'h4;
        tick(1);
        chk("wrap", next_fetch_pointer, 20'h00002);
        pc_op = CPUREG_PC_HOLD;
        cbank_we = 1'b1;
        bank_wdata = 8'h05;
        tick(1);
        cbank_we = 1'b0;
        pc_op = CPUREG_PC_JREG;
        branch_reg = 16'h4321;
        tick(1);
        chk("jreg", next_fetch_pointer, 20'h54321);
        pc_op = CPUREG_PC_HOLD;
        $display("fetch test done");
    endtask
    // Flag updates, then a restore that must override them
    task automatic t_flags();
        flag_upd = 6'h3F;
        tick(1);
        chk("set", status_word, 8'h57);
        flag_upd = 6'h2A;
        tick(1);
        chk("clear", status_word, 8'h06);
        status_load = 1'b1;
        status_wdata = 8'h82;
        flag_upd = 6'h3F;
        tick(1);
        chk("restore", status_word, 8'h82);
        {status_load, flag_upd} = '0;
        $display("flag test done");
    endtask
    task automatic t_irq();
        irq_pending = 1'b1;
        // Each level held over one edge so inputs only move just after a rising edge
        for (int l = 0; l < 4; l++) begin
            irq_level = 2'(l);
            tick(1);
            chk("level", irq_take, l <= 1);
        end
        irq_level = 2'h0;
        {block_irq_instr, allow_irq_instr} = 2'b11;
        tick(1);
        chk("block", {status_word, irq_take}, 9'h004);
        block_irq_instr = 1'b0;
        tick(1);
        allow_irq_instr = 1'b0;
        irq_ack = 1'b1;
        #1 chk("push", {status_push, status_push_data}, 9'h182);
        tick(1);
        irq_ack = 1'b0;
        chk("ack", status_word, 8'h02);
        $display("interrupt test done");
    endtask
    // Stack set inside internal RAM before its first use
    task automatic t_stack();
        sp_op = CPUREG_SP_LOAD;
        sp_wdata = 16'hFE20;
        tick(1);
        sp_op = CPUREG_SP_PUSH;
        #1 chk("push addr", stack_addr, 20'hFFE1F);
        tick(1);
        sp_op = CPUREG_SP_POP;
        #1 chk("pop addr", {stack_top_ptr, stack_addr}, 36'hFE1FFFE1F);
        tick(1);
        sp_op = CPUREG_SP_NONE;
        chk("popped", stack_top_ptr, 16'hFE20);
        $display("stack test done");
    endtask
    task automatic t_data();
        // Combinational outputs read 1 ns after the drive; the next drive waits for an edge
        data_offset = 16'hFF00;
        dbank_we = 1'b1;
        bank_wdata = 8'h02;
        #1 chk("sfr", {data_hit_sfr, data_addr}, 21'h1FFF00);
        tick(1);
        {dbank_we, data_use_bank} = 2'b01;
        data_offset = 16'h1234;
        #1 chk("bank", data_addr, 20'h21234);
        tick(1);
        {data_use_bank, data_we} = 2'b01;
        for (int i = 0; i < 2; i++) begin
            data_offset = 16'hFEF8 + 16'(i);
            data_wdata = i ? 8'h5A : 8'hA5;
            tick(1);
        end
        data_we = 1'b0;
        pair_sel = 2'h0;
        #1 chk("pair", {gpr_rdata, pair_rdata}, 24'h5A5AA5);
        tick(1);
        {pair_we, pair_sel, pair_wdata} = 19'h7BEEF;
        tick(1);
        pair_we = 1'b0;
        data_offset = 16'hFEFE;
        #1 chk("byte", {data_hit_sfr, gpr_rdata}, 9'h0EF);
        tick(1);
        $display("data test done");
    endtask
    initial begin
        {status_load, block_irq_instr, allow_irq_instr, irq_ack, irq_pending, data_use_bank, data_we} = '0;
        {pair_we, dbank_we, cbank_we, slow, rst, flag_upd} = '0;
        {branch_target, branch_reg, sp_wdata, data_offset, pair_wdata} = '0;
        {status_wdata, data_wdata, bank_wdata, instr_len, irq_level, pair_sel} = '0;
        pc_op = CPUREG_PC_HOLD;
        sp_op = CPUREG_SP_NONE;
        t_reset(1'b0);
        t_fetch();
        t_flags();
        t_irq();
        t_stack();
        t_data();
        t_reset(1'b1);
        stop_test();
    end
endmodule
`default_nettype wire
